// [hw/pmc_pkg.sv]
// constants, field layouts and carrier types of the power-mode clock manager
// assumes a single 100 MHz system clock and an apb master on the same clock
//
// Contract
// - primary oscillator runs only in primary modes
// - secondary modes run and use secondary oscillator
// - secondary oscillator may run in every mode
// - internal modes clock from internal rc oscillator
// - sleep stops all sources except kept ones
// - watchdog enabled keeps internal rc running
// - fixed power-up timer holds reset, always on
// - crystal start-up counts 1024 primary cycles
// - cpu ready delay before first instruction
// - external clock sleep drives output pin low
// - idle bit 7, select field bits 1:0
// - select write switches source when it runs
// - sleep trigger enters sleep or matching idle
// - sleep clocks neither cpu nor peripherals
// - select codes 10/01/11; run clocks everything
// - idle stops cpu, peripherals keep selected source
// - switch pauses two old, three new cycles
// - status bits show primary or secondary source
// - each sleep trigger reads current idle bit
// - every reset clears select field to 00
// - select 00 follows default-source configuration bit
package pmc_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int POWER_UP_TIMER_TIME_US = 64;
   localparam int POWER_UP_TIMER_CYCLES = (POWER_UP_TIMER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_TIME_US = 10;
   localparam int READY_CYCLES = (READY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] READY_LAST = 16'(READY_CYCLES - 1);
   localparam logic [CNT_W-1:0] OST_LAST = 16'h03ff;
   localparam logic [CNT_W-1:0] SW_OLD_LAST = 16'h0001;
   localparam logic [CNT_W-1:0] SW_NEW_LAST = 16'h0002;
   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_OSC_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_TMR_CTRL = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00c;
   localparam int OSC_IDLE_BIT = 7;
   localparam int OSC_PRI_STAT_BIT = 3;
   localparam int OSC_SEL_LSB = 0;
   localparam int TMR_SECRUN_BIT = 6;
   localparam int TMR_SECEN_BIT = 3;
   localparam int CFG_DEFSRC_BIT = 0;
   localparam int CFG_EXTCLK_BIT = 1;
   localparam int CFG_WDT_BIT = 2;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_HOLD_BIT = 4;
   localparam int STAT_READY_BIT = 5;
   localparam logic [1:0] SEL_DEFAULT = 2'h0;
   localparam logic [1:0] SEL_SEC = 2'h1;
   localparam logic [1:0] SEL_PRI = 2'h2;
   localparam logic [1:0] SEL_RC = 2'h3;
   localparam logic SEL_RESET_IDLE = 1'b0;
   localparam logic DEFSRC_RESET = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {SRC_NONE, SRC_PRI, SRC_SEC, SRC_RC} pmc_src_t;
   typedef enum logic [3:0] {ST_PWRUP, ST_OST, ST_READY, ST_RUN, ST_START, ST_SW_OLD, ST_SW_NEW,
                             ST_IDLE, ST_SLEEP} pmc_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } pmc_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pmc_apb_rsp_t;
   typedef struct packed {
      logic cpuClkEn;
      logic periphClkEn;
      logic priOscEnable;
      logic secOscRun;
      logic rcOscEnable;
      pmc_src_t source;
   } pmc_clk_t;
   typedef struct packed {
      logic idleSel;
      logic [1:0] srcSel;
      logic secEnable;
      logic defaultCfg;
      logic extClkMode;
      logic wdtEnable;
      logic porBoot;
      pmc_state_t state;
      pmc_src_t active;
      pmc_src_t target;
      logic [CNT_W-1:0] count;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] sync3;
      logic [2:0] filt;
      logic [1:0] div;
      logic outPin;
      logic [31:0] prdata;
      logic slverr;
   } pmc_regs_t;
endpackage

// [hw/pmc_power_mode_clock_manager.sv]
// power-mode controller: picks cpu/peripheral clocking and source, switches glitch-free
// assumes oscillator outputs arrive as asynchronous pins; sleep/wake pulses come from core logic on mclk
//
// Added by the designer: the placing of the registers and the APB slave port.
module pmc_power_mode_clock_manager #(
   parameter int PWR_UP_CYCLES = pmc_pkg::POWER_UP_TIMER_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register bus
   input wire pmc_pkg::pmc_apb_req_t apbReq,
   output pmc_pkg::pmc_apb_rsp_t apbRsp,
   // core events
   input wire logic sleepExec,
   input wire logic wakeEvent,
   // oscillator pins: 0 primary, 1 secondary, 2 internal rc
   input wire logic [2:0] oscIn,
   // clock control
   output pmc_pkg::pmc_clk_t clocks,
   output logic resetHold,
   output logic cpuReady,
   output logic primaryClockStatus,
   output logic secondaryRunStatus,
   // crystal output pin
   output logic crystalOutPin,
   output logic crystalOutEn
);
   localparam logic [pmc_pkg::CNT_W-1:0] PWR_LAST = 16'(PWR_UP_CYCLES - 1);

   pmc_pkg::pmc_regs_t st;
   pmc_pkg::pmc_regs_t next_;
   logic [1:0] rstSync;
   logic rstInt_n;
   logic [2:0] rise;
   logic wr;
   logic rdSetup;
   pmc_pkg::pmc_src_t tgt;

   function automatic pmc_pkg::pmc_src_t srcOf(input logic [1:0] sel, input logic defCfg);
      case (sel)
         pmc_pkg::SEL_PRI: srcOf = pmc_pkg::SRC_PRI;
         pmc_pkg::SEL_SEC: srcOf = pmc_pkg::SRC_SEC;
         pmc_pkg::SEL_RC: srcOf = pmc_pkg::SRC_RC;
         default: srcOf = defCfg ? pmc_pkg::SRC_PRI : pmc_pkg::SRC_RC;
      endcase
   endfunction

   function automatic logic tickOf(input pmc_pkg::pmc_src_t src, input logic [2:0] edges);
      case (src)
         pmc_pkg::SRC_PRI: tickOf = edges[0];
         pmc_pkg::SRC_SEC: tickOf = edges[1];
         pmc_pkg::SRC_RC: tickOf = edges[2];
         default: tickOf = 1'b0;
      endcase
   endfunction

   function automatic logic needsOst(input pmc_pkg::pmc_src_t src, input logic extClk);
      needsOst = (src == pmc_pkg::SRC_PRI) && !extClk;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // reset release
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstInt_n = rstSync[1];

   ////////////////////////////////////////////////////////////////////////////////
   // decode helpers
   // an edge counts once the second and third stages agree; the first stage feeds only the second
   assign rise = st.sync2 & st.sync3 & ~st.filt;
   assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign rdSetup = apbReq.psel && !apbReq.penable;
   assign tgt = srcOf(st.srcSel, st.defaultCfg);

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_ = st;
      next_.sync1 = oscIn;
      next_.sync2 = st.sync1;
      next_.sync3 = st.sync2;
      for (int i = 0; i < 3; i++) begin
         if (st.sync2[i] == st.sync3[i]) begin
            next_.filt[i] = st.sync3[i];
         end
      end
      // crystal output carries primary clock divided by four, held low in sleep
      if (rise[0]) begin
         next_.div = st.div + 2'h1;
      end
      next_.outPin = (st.extClkMode && st.state != pmc_pkg::ST_SLEEP) ? st.div[1] : 1'b0;

      // register writes take effect at the access edge
      if (wr) begin
         case (apbReq.paddr)
            pmc_pkg::ADDR_OSC_CTRL: begin
               next_.idleSel = apbReq.pwdata[pmc_pkg::OSC_IDLE_BIT];
               // selecting a stopped secondary oscillator would hang the clock, so it is dropped
               if (!(apbReq.pwdata[pmc_pkg::OSC_SEL_LSB +: 2] == pmc_pkg::SEL_SEC && !st.secEnable)) begin
                  next_.srcSel = apbReq.pwdata[pmc_pkg::OSC_SEL_LSB +: 2];
               end
            end
            pmc_pkg::ADDR_TMR_CTRL: begin
               next_.secEnable = apbReq.pwdata[pmc_pkg::TMR_SECEN_BIT];
            end
            pmc_pkg::ADDR_CONFIG: begin
               next_.defaultCfg = apbReq.pwdata[pmc_pkg::CFG_DEFSRC_BIT];
               next_.extClkMode = apbReq.pwdata[pmc_pkg::CFG_EXTCLK_BIT];
               next_.wdtEnable = apbReq.pwdata[pmc_pkg::CFG_WDT_BIT];
            end
            default: begin
            end
         endcase
      end

      // read data is prepared in the setup cycle so the access phase needs no wait state
      if (rdSetup) begin
         next_.prdata = 32'h0000_0000;
         next_.slverr = 1'b0;
         case (apbReq.paddr)
            pmc_pkg::ADDR_OSC_CTRL: begin
               next_.prdata[pmc_pkg::OSC_IDLE_BIT] = st.idleSel;
               next_.prdata[pmc_pkg::OSC_PRI_STAT_BIT] = (st.active == pmc_pkg::SRC_PRI);
               next_.prdata[pmc_pkg::OSC_SEL_LSB +: 2] = st.srcSel;
            end
            pmc_pkg::ADDR_TMR_CTRL: begin
               next_.prdata[pmc_pkg::TMR_SECRUN_BIT] = (st.active == pmc_pkg::SRC_SEC);
               next_.prdata[pmc_pkg::TMR_SECEN_BIT] = st.secEnable;
            end
            pmc_pkg::ADDR_CONFIG: begin
               next_.prdata[pmc_pkg::CFG_DEFSRC_BIT] = st.defaultCfg;
               next_.prdata[pmc_pkg::CFG_EXTCLK_BIT] = st.extClkMode;
               next_.prdata[pmc_pkg::CFG_WDT_BIT] = st.wdtEnable;
            end
            pmc_pkg::ADDR_STATUS: begin
               next_.prdata[pmc_pkg::STAT_STATE_LSB +: 4] = st.state;
               next_.prdata[pmc_pkg::STAT_HOLD_BIT] = resetHold;
               next_.prdata[pmc_pkg::STAT_READY_BIT] = cpuReady;
            end
            default: begin
               next_.slverr = 1'b1;
            end
         endcase
      end

      // mode sequencing
      case (st.state)
         pmc_pkg::ST_PWRUP: begin
            next_.count = st.count + 16'h0001;
            if (st.count == PWR_LAST) begin
               next_.count = '0;
               next_.target = tgt;
               next_.state = needsOst(tgt, st.extClkMode) ? pmc_pkg::ST_OST : pmc_pkg::ST_READY;
            end
         end
         pmc_pkg::ST_OST: begin
            if (rise[0]) begin
               next_.count = st.count + 16'h0001;
               if (st.count == pmc_pkg::OST_LAST) begin
                  next_.count = '0;
                  next_.state = pmc_pkg::ST_READY;
               end
            end
         end
         pmc_pkg::ST_READY: begin
            next_.count = st.count + 16'h0001;
            if (st.count == pmc_pkg::READY_LAST) begin
               next_.count = '0;
               next_.active = st.target;
               next_.porBoot = 1'b0;
               next_.state = pmc_pkg::ST_RUN;
            end
         end
         pmc_pkg::ST_RUN: begin
            if (sleepExec) begin
               // idle bit is read at the trigger itself, so every sleep follows the current setting
               if (st.idleSel) begin
                  next_.state = pmc_pkg::ST_IDLE;
               end else begin
                  next_.state = pmc_pkg::ST_SLEEP;
                  next_.active = pmc_pkg::SRC_NONE;
                  next_.target = pmc_pkg::SRC_NONE;
               end
            end else if (tgt != st.active) begin
               next_.target = tgt;
               next_.count = '0;
               next_.state = needsOst(tgt, st.extClkMode) ? pmc_pkg::ST_START : pmc_pkg::ST_SW_OLD;
            end
         end
         pmc_pkg::ST_START: begin
            // the old source keeps clocking while the crystal comes up
            if (rise[0]) begin
               next_.count = st.count + 16'h0001;
               if (st.count == pmc_pkg::OST_LAST) begin
                  next_.count = '0;
                  next_.state = pmc_pkg::ST_SW_OLD;
               end
            end
         end
         pmc_pkg::ST_SW_OLD: begin
            if (tickOf(st.active, rise)) begin
               next_.count = st.count + 16'h0001;
               if (st.count == pmc_pkg::SW_OLD_LAST) begin
                  next_.count = '0;
                  next_.state = pmc_pkg::ST_SW_NEW;
               end
            end
         end
         pmc_pkg::ST_SW_NEW: begin
            if (tickOf(st.target, rise)) begin
               next_.count = st.count + 16'h0001;
               if (st.count == pmc_pkg::SW_NEW_LAST) begin
                  next_.count = '0;
                  next_.active = st.target;
                  next_.state = pmc_pkg::ST_RUN;
               end
            end
         end
         pmc_pkg::ST_IDLE: begin
            if (wakeEvent) begin
               next_.count = '0;
               next_.state = pmc_pkg::ST_READY;
            end
         end
         pmc_pkg::ST_SLEEP: begin
            if (wakeEvent) begin
               next_.count = '0;
               next_.target = tgt;
               next_.state = needsOst(tgt, st.extClkMode) ? pmc_pkg::ST_OST : pmc_pkg::ST_READY;
            end
         end
         default: begin
            next_.state = pmc_pkg::ST_PWRUP;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         st <= '0;
         st.idleSel <= pmc_pkg::SEL_RESET_IDLE;
         st.srcSel <= pmc_pkg::SEL_DEFAULT;
         st.defaultCfg <= pmc_pkg::DEFSRC_RESET;
         st.porBoot <= 1'b1;
         st.state <= pmc_pkg::ST_PWRUP;
         st.active <= pmc_pkg::SRC_RC;
         st.target <= pmc_pkg::SRC_RC;
      end else begin
         st <= next_;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   always_comb begin
      clocks.cpuClkEn = (st.state == pmc_pkg::ST_RUN) || (st.state == pmc_pkg::ST_START);
      clocks.periphClkEn = clocks.cpuClkEn || (st.state == pmc_pkg::ST_IDLE) ||
                           (st.state == pmc_pkg::ST_READY);
      clocks.priOscEnable = (st.state != pmc_pkg::ST_SLEEP) &&
                            ((st.active == pmc_pkg::SRC_PRI) || (st.target == pmc_pkg::SRC_PRI));
      clocks.secOscRun = st.secEnable;
      clocks.rcOscEnable = st.wdtEnable || (st.state == pmc_pkg::ST_PWRUP) ||
                           (st.active == pmc_pkg::SRC_RC) || (st.target == pmc_pkg::SRC_RC);
      if (clocks.cpuClkEn || st.state == pmc_pkg::ST_IDLE) begin
         clocks.source = st.active;
      end else if (st.state == pmc_pkg::ST_READY) begin
         clocks.source = st.target;
      end else begin
         clocks.source = pmc_pkg::SRC_NONE;
      end
   end
   assign resetHold = st.porBoot && ((st.state == pmc_pkg::ST_PWRUP) || (st.state == pmc_pkg::ST_OST));
   assign cpuReady = (st.state == pmc_pkg::ST_RUN);
   assign primaryClockStatus = (st.active == pmc_pkg::SRC_PRI);
   assign secondaryRunStatus = (st.active == pmc_pkg::SRC_SEC);
   assign crystalOutPin = st.outPin;
   assign crystalOutEn = st.extClkMode;
   assign apbRsp.prdata = st.prdata;
   assign apbRsp.pready = 1'b1;
   assign apbRsp.pslverr = st.slverr;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   logic [10:0] ostSeen;
   always_ff @(posedge mclk or negedge rstInt_n) begin
      if (!rstInt_n) begin
         ostSeen <= 11'h000;
      end else if (st.state == pmc_pkg::ST_OST) begin
         ostSeen <= ostSeen + {10'h000, rise[0]};
      end else begin
         ostSeen <= 11'h000;
      end
   end

   a_ost_full_count: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_OST && next_.state == pmc_pkg::ST_READY) |-> (ostSeen == 11'h3ff && rise[0]))
      else $error("start-up timer ended before 1024 primary edges");
   a_sleep_no_clocks: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_SLEEP) |-> (!clocks.cpuClkEn && !clocks.periphClkEn &&
                                            !clocks.priOscEnable && clocks.source == pmc_pkg::SRC_NONE))
      else $error("clock active in sleep");
   a_idle_cpu_off: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_IDLE) |-> (!clocks.cpuClkEn && clocks.periphClkEn && clocks.source == tgt))
      else $error("idle clocking wrong");
   a_wdt_keeps_rc: assert property (@(posedge mclk) disable iff (!rstInt_n)
      st.wdtEnable |-> clocks.rcOscEnable)
      else $error("internal rc stopped with watchdog on");
   a_status_in_pause: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_SW_OLD) |=> $stable(primaryClockStatus) && $stable(secondaryRunStatus))
      else $error("status moved during switch pause");
   a_sleep_entry: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_RUN && sleepExec && !st.idleSel) |=>
         (st.state == pmc_pkg::ST_SLEEP && !primaryClockStatus && !secondaryRunStatus))
      else $error("sleep trigger did not enter sleep");
   a_pin_low_sleep: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_SLEEP) [*2] |-> !crystalOutPin)
      else $error("crystal output not low in sleep");
   a_select_reset: assert property (@(posedge mclk)
      $rose(rstInt_n) |-> (st.srcSel == pmc_pkg::SEL_DEFAULT && resetHold))
      else $error("select field not cleared by reset");
   a_sec_ignored: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (wr && apbReq.paddr == pmc_pkg::ADDR_OSC_CTRL && !st.secEnable &&
       apbReq.pwdata[1:0] == pmc_pkg::SEL_SEC) |=> $stable(st.srcSel))
      else $error("disabled secondary oscillator was selected");
   a_run_clocks: assert property (@(posedge mclk) disable iff (!rstInt_n)
      cpuReady |-> (clocks.periphClkEn && clocks.source == st.active && st.active != pmc_pkg::SRC_NONE))
      else $error("run mode without clocks");

   a_primary_idle_mode_on: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_IDLE) |-> (clocks.priOscEnable == (st.active == pmc_pkg::SRC_PRI)))
      else $error("primary enable wrong in idle");

   a_secondary_run_mode_clock: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (cpuReady && st.active == pmc_pkg::SRC_SEC) |-> (clocks.secOscRun && clocks.source == pmc_pkg::SRC_SEC))
      else $error("secondary run without secondary clock");

   a_internal_run_mode_clock: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (cpuReady && st.active == pmc_pkg::SRC_RC) |-> (clocks.rcOscEnable && clocks.source == pmc_pkg::SRC_RC))
      else $error("internal run without internal clock");

   a_ost_crystal: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_OST) |-> (!st.extClkMode && st.target == pmc_pkg::SRC_PRI))
      else $error("start-up timer outside crystal primary");

   a_ready_cpu_off: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_READY) |-> (!clocks.cpuClkEn && !cpuReady))
      else $error("cpu clocked during ready delay");

   a_select_switch: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (cpuReady && !sleepExec && tgt != st.active) |=>
         (st.state == pmc_pkg::ST_SW_OLD || st.state == pmc_pkg::ST_START))
      else $error("select change did not start a switch");

   a_idle_entry: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (cpuReady && sleepExec && st.idleSel) |=>
         (st.state == pmc_pkg::ST_IDLE && $stable(primaryClockStatus) && $stable(secondaryRunStatus)))
      else $error("sleep trigger did not enter idle");

   a_pause_dark: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.state == pmc_pkg::ST_SW_OLD || st.state == pmc_pkg::ST_SW_NEW) |->
         (!clocks.periphClkEn && clocks.source == pmc_pkg::SRC_NONE))
      else $error("clock running in switch pause");

   a_status_exact: assert property (@(posedge mclk) disable iff (!rstInt_n)
      cpuReady |-> (primaryClockStatus == (clocks.source == pmc_pkg::SRC_PRI) &&
                    secondaryRunStatus == (clocks.source == pmc_pkg::SRC_SEC)))
      else $error("status bits disagree with source");

   a_default_pick: assert property (@(posedge mclk) disable iff (!rstInt_n)
      (st.srcSel == pmc_pkg::SEL_DEFAULT) |-> (tgt == (st.defaultCfg ? pmc_pkg::SRC_PRI : pmc_pkg::SRC_RC)))
      else $error("default select picked wrong source");
endmodule

// [tb/pmc_osc_model.sv]
// oscillator model: primary, secondary and internal rc pins feeding the clock manager
// assumes each enable comes from the manager; a disabled oscillator stops low
module pmc_osc_model #(
   parameter int HALF0 = 3,
   parameter int HALF1 = 5,
   parameter int HALF2 = 4
) (
   // clock
   input wire logic mclk,
   // enables: 0 primary, 1 secondary, 2 internal rc
   input wire logic [2:0] run,
   // oscillator pins
   output logic [2:0] osc
);
   timeunit 1ns;
   timeprecision 1ps;
   int half [3];
   int cnt [3];
   initial begin
      osc = 3'h0;
      half[0] = HALF0;
      half[1] = HALF1;
      half[2] = HALF2;
      cnt[0] = 0;
      cnt[1] = 0;
      cnt[2] = 0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // halves of several mclk cycles keep every level long enough for the 3-flop sync
   always @(posedge mclk) begin
      for (int k = 0; k < 3; k++) begin
         if (!run[k]) begin
            osc[k] <= 1'b0;
            cnt[k] <= 0;
         end else if (cnt[k] == half[k] - 1) begin
            osc[k] <= ~osc[k];
            cnt[k] <= 0;
         end else begin
            cnt[k] <= cnt[k] + 1;
         end
      end
   end
endmodule

// [tb/test_power_mode_clock_manager.sv]
// self-checking bench for the power-mode clock manager, driven over apb and core pulses
// assumes pmc_osc_model supplies the oscillator pins and mclk runs at 100 MHz
module test_power_mode_clock_manager;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic sleepExec = 1'b0;
   logic wakeEvent = 1'b0;
   pmc_pkg::pmc_apb_req_t apbReq = '0;
   pmc_pkg::pmc_apb_rsp_t apbRsp;
   pmc_pkg::pmc_clk_t clocks;
   logic [2:0] oscIn;
   logic resetHold;
   logic cpuReady;
   logic primaryClockStatus;
   logic secondaryRunStatus;
   logic crystalOutPin;
   logic crystalOutEn;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   pmc_power_mode_clock_manager #(.PWR_UP_CYCLES(20)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .sleepExec(sleepExec),
      .wakeEvent(wakeEvent), .oscIn(oscIn), .clocks(clocks), .resetHold(resetHold), .cpuReady(cpuReady),
      .primaryClockStatus(primaryClockStatus), .secondaryRunStatus(secondaryRunStatus),
      .crystalOutPin(crystalOutPin), .crystalOutEn(crystalOutEn));
   pmc_osc_model osc_u (
      .mclk(mclk), .run({clocks.rcOscEnable, clocks.secOscRun, clocks.priOscEnable}), .osc(oscIn));
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////////
   // tasks
   task automatic tally_and_finish;
      if (n_fail == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
      @(posedge mclk);
      apbReq.psel <= 1'b1;
      apbReq.pwrite <= w;
      apbReq.paddr <= a;
      apbReq.pwdata <= d;
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      @(posedge mclk);
      while (apbRsp.pready !== 1'b1) @(posedge mclk);
      q = {apbRsp.pslverr, apbRsp.prdata};
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      logic [32:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(q[31:0], exp[31:0]);
      chk({31'h0, q[32]}, {31'h0, exp[32]});
   endtask
   task automatic look(input logic cpu, per, input pmc_pkg::pmc_src_t src, input logic ps, ss);
      chk({26'h0, clocks.cpuClkEn, clocks.periphClkEn, clocks.source, primaryClockStatus, secondaryRunStatus},
         {26'h0, cpu, per, src, ps, ss});
   endtask
   task automatic en(input logic pri, sec, rc);
      chk({29'h0, clocks.priOscEnable, clocks.secOscRun, clocks.rcOscEnable}, {29'h0, pri, sec, rc});
   endtask
   task automatic pulse(input logic s);
      @(posedge mclk);
      if (s) sleepExec <= 1'b1;
      else wakeEvent <= 1'b1;
      @(posedge mclk);
      sleepExec <= 1'b0;
      wakeEvent <= 1'b0;
      #1;
   endtask
   task automatic wake;
      pulse(1'b0);
      wait (cpuReady === 1'b1);
      @(posedge mclk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // hang guard: the whole sequence needs about 17000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (20) @(posedge mclk);
      chk({cpuReady, resetHold}, 32'h1);
      rst_n <= 1'b1;
      n = 0;
      while (resetHold !== 1'b0) begin
         @(posedge mclk);
         n++;
      end
      chk(32'(n >= 20 + 1023 * 6), 32'h1);
      n = 0;
      while (cpuReady !== 1'b1) begin
         @(posedge mclk);
         n++;
      end
      chk(32'(n >= pmc_pkg::READY_CYCLES - 2 && n <= pmc_pkg::READY_CYCLES + 2), 32'h1);
      #1;
      look(1'b1, 1'b1, pmc_pkg::SRC_PRI, 1'b1, 1'b0);
      rd(pmc_pkg::ADDR_OSC_CTRL, 33'h008);
      rd(pmc_pkg::ADDR_TMR_CTRL, 33'h000);
      rd(12'h010, 33'h100000000);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h03);
      wait (clocks.source === pmc_pkg::SRC_NONE);
      chk({31'h0, primaryClockStatus}, 32'h1);
      n = 0;
      while (clocks.source !== pmc_pkg::SRC_RC) begin
         @(posedge mclk);
         n++;
      end
      chk(32'(n >= 20 && n <= 50), 32'h1);
      #1;
      look(1'b1, 1'b1, pmc_pkg::SRC_RC, 1'b0, 1'b0);
      en(1'b0, 1'b0, 1'b1);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h01);
      repeat (60) @(posedge mclk);
      rd(pmc_pkg::ADDR_OSC_CTRL, 33'h003);
      wr(pmc_pkg::ADDR_TMR_CTRL, 32'h08);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h01);
      wait (clocks.source === pmc_pkg::SRC_SEC);
      @(posedge mclk);
      #1;
      look(1'b1, 1'b1, pmc_pkg::SRC_SEC, 1'b0, 1'b1);
      rd(pmc_pkg::ADDR_TMR_CTRL, 33'h048);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h81);
      pulse(1'b1);
      look(1'b0, 1'b1, pmc_pkg::SRC_SEC, 1'b0, 1'b1);
      wake();
      // a second sleep follows the idle bit as it now stands
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h01);
      pulse(1'b1);
      look(1'b0, 1'b0, pmc_pkg::SRC_NONE, 1'b0, 1'b0);
      en(1'b0, 1'b1, 1'b0);
      wake();
      wr(pmc_pkg::ADDR_CONFIG, 32'h06);
      pulse(1'b1);
      en(1'b0, 1'b1, 1'b1);
      @(posedge mclk);
      #1;
      chk({crystalOutEn, crystalOutPin}, 32'h2);
      wake();
      wr(pmc_pkg::ADDR_CONFIG, 32'h01);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h02);
      wait (clocks.source === pmc_pkg::SRC_PRI);
      @(posedge mclk);
      #1;
      look(1'b1, 1'b1, pmc_pkg::SRC_PRI, 1'b1, 1'b0);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h82);
      pulse(1'b1);
      look(1'b0, 1'b1, pmc_pkg::SRC_PRI, 1'b1, 1'b0);
      en(1'b1, 1'b1, 1'b0);
      wake();
      wr(pmc_pkg::ADDR_CONFIG, 32'h00);
      wr(pmc_pkg::ADDR_OSC_CTRL, 32'h00);
      wait (clocks.source === pmc_pkg::SRC_RC);
      @(posedge mclk);
      #1;
      look(1'b1, 1'b1, pmc_pkg::SRC_RC, 1'b0, 1'b0);
      tally_and_finish();
   end
endmodule
